// ---- design/pwl_pkg.sv ----
// Purpose: constants for the pwm register write lock
// Assumes: 16-bit special-function-register bus, one access per cycle at most
// Notes:   key values and option bit position are fixed by the device
package pwl_pkg;
   localparam int           DATA_W          = 16;
   localparam logic [15:0]  KEY_FIRST       = 16'habcd;
   localparam logic [15:0]  KEY_SECOND      = 16'h4321;
   localparam int           LOCK_OPT_BIT    = 0;
   localparam int           OPT_W           = 16;
   localparam logic [15:0]  OPT_WORD_ERASED = 16'hffff;

   typedef enum logic [1:0] {
      PWL_LOCKED,
      PWL_KEY1_SEEN,
      PWL_ARMED
   } pwl_state_t;
endpackage : pwl_pkg

// ---- design/pwl_opt_latch.sv ----
// Purpose: captures the protection option bit from the device options word
// Assumes: options word is stable while reset is low
// Notes:   erased (unprogrammed) word reads all ones, so protection is on
`timescale 1ns/1ps
`default_nettype none
module pwl_opt_latch (
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   input  wire logic [pwl_pkg::OPT_W-1:0]  device_options_config_word,
   output var  logic                       pwm_protect_config_bit
);
   import pwl_pkg::*;
   logic protect_reg;
   logic protect_next;

   // strap is caught while reset is held, not by an asynchronous load
   always_comb begin
      protect_next = protect_reg;
      if (!rst_n) begin
         protect_next = device_options_config_word[LOCK_OPT_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      protect_reg <= protect_next;
   end

   assign pwm_protect_config_bit = protect_reg;   // erased one means protected
endmodule : pwl_opt_latch
`default_nettype wire

// ---- design/pwl_write_lock.sv ----
// Purpose: write-protection gate for pwm output-control and fault-control registers
// Assumes: one sfr access per cycle; access strobe covers reads and writes
// Notes:   write enables are registered, so the pwm register updates one cycle later
`timescale 1ns/1ps
`default_nettype none
module pwl_write_lock (
   input  wire logic                        sys_clk,
   input  wire logic                        rst_n,
   input  wire logic [pwl_pkg::OPT_W-1:0]   device_options_config_word,
   input  wire logic                        sfr_access,
   input  wire logic                        sfr_write,
   input  wire logic                        sel_key,
   input  wire logic                        sel_output_control,
   input  wire logic                        sel_fault_control,
   input  wire logic [pwl_pkg::DATA_W-1:0]  sfr_wdata,
   output var  logic                        pwm_output_control_we,
   output var  logic                        pwm_fault_control_we,
   output var  logic [pwl_pkg::DATA_W-1:0]  pwm_wdata,
   output var  logic                        unlock_armed,
   output var  logic                        write_blocked
);
   import pwl_pkg::*;

   logic              protect_en;
   pwl_state_t        state_reg;
   pwl_state_t        state_next;
   logic              oc_we_reg;
   logic              oc_we_next;
   logic              fc_we_reg;
   logic              fc_we_next;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] wdata_next;
   logic              blocked_reg;
   logic              blocked_next;
   logic              key_wr;
   logic              prot_wr;
   logic              grant;
   // armed copy kept as a flop so the status pin has no decode behind it
   logic              armed_reg;
   logic              armed_next;

   pwl_opt_latch u_opt (
      .sys_clk                    (sys_clk),
      .rst_n                      (rst_n),
      .device_options_config_word (device_options_config_word),
      .pwm_protect_config_bit     (protect_en)
   );

   assign key_wr  = sfr_access && sfr_write && sel_key;
   assign prot_wr = sfr_access && sfr_write && (sel_output_control || sel_fault_control);

   // key compare shared by both key states of the sequencer
   function automatic logic key_match(
      input logic              wr,
      input logic [DATA_W-1:0] word,
      input logic [DATA_W-1:0] key
   );
      return wr && (word == key);
   endfunction : key_match

   // key sequencer; any access not continuing the sequence drops back to locked
   always_comb begin
      state_next = state_reg;
      if (sfr_access) begin
         unique case (state_reg)
            PWL_LOCKED: begin
               state_next = key_match(key_wr, sfr_wdata, KEY_FIRST) ? PWL_KEY1_SEEN : PWL_LOCKED;
            end
            PWL_KEY1_SEEN: begin
               state_next = key_match(key_wr, sfr_wdata, KEY_SECOND) ? PWL_ARMED : PWL_LOCKED;
            end
            PWL_ARMED: begin
               // whatever the next access is, the arming is spent
               state_next = PWL_LOCKED;
            end
            default: begin
               state_next = PWL_LOCKED;
            end
         endcase
      end
      armed_next = (state_next == PWL_ARMED);
   end

   // write gate; protection off passes every write
   always_comb begin
      grant        = !protect_en || (state_reg == PWL_ARMED);
      oc_we_next   = 1'b0;
      fc_we_next   = 1'b0;
      wdata_next   = wdata_reg;
      blocked_next = 1'b0;
      if (prot_wr) begin
         if (grant) begin
            oc_we_next = sel_output_control;
            fc_we_next = sel_fault_control;
            wdata_next = sfr_wdata;
         end else begin
            blocked_next = 1'b1;
         end
      end
   end

   // reset clears the gate only; the option strap lives in its own latch
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg   <= PWL_LOCKED;
         oc_we_reg   <= 1'b0;
         fc_we_reg   <= 1'b0;
         wdata_reg   <= '0;
         blocked_reg <= 1'b0;
         armed_reg   <= 1'b0;
      end else begin
         state_reg   <= state_next;
         oc_we_reg   <= oc_we_next;
         fc_we_reg   <= fc_we_next;
         wdata_reg   <= wdata_next;
         blocked_reg <= blocked_next;
         armed_reg   <= armed_next;
      end
   end

   // every output leaves straight from a flop
   assign pwm_output_control_we = oc_we_reg;
   assign pwm_fault_control_we  = fc_we_reg;
   assign pwm_wdata             = wdata_reg;
   assign write_blocked         = blocked_reg;
   assign unlock_armed          = armed_reg;

   chk_locked_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (protect_en && state_reg == PWL_LOCKED && prot_wr) |=> (!oc_we_reg && !fc_we_reg && blocked_reg))
      else $error("protected write passed while locked");
   chk_open_passes: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!protect_en && prot_wr && sel_output_control) |=> oc_we_reg)
      else $error("write lost with protection off");
   chk_key_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_reg == PWL_LOCKED && key_wr && sfr_wdata == KEY_SECOND) |=> state_reg == PWL_LOCKED)
      else $error("second key alone armed the gate");
   chk_full_unlock: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_reg == PWL_LOCKED && key_wr && sfr_wdata == KEY_FIRST)
      ##1 (key_wr && sfr_wdata == KEY_SECOND) ##1 (prot_wr && sel_fault_control) |=> fc_we_reg)
      else $error("valid unlock did not grant write");
   chk_interrupt_voids: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_reg == PWL_KEY1_SEEN && sfr_access && !key_wr) |=> state_reg == PWL_LOCKED)
      else $error("intervening access kept key progress");
   chk_single_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (protect_en && state_reg == PWL_ARMED && prot_wr) ##1 prot_wr |=> !oc_we_reg && !fc_we_reg)
      else $error("two writes from one unlock");
   chk_armed_relocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_reg == PWL_ARMED && sfr_access) |=> state_reg == PWL_LOCKED)
      else $error("gate stayed armed after access");
   chk_we_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
      oc_we_reg |-> $past(prot_wr) && ($past(!protect_en) || $past(state_reg == PWL_ARMED)))
      else $error("write enable without cause");

   // sequence corners and gate side effects
   chk_key1_progress: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_reg == PWL_LOCKED && key_wr && sfr_wdata == KEY_FIRST)
      |=> state_reg == PWL_KEY1_SEEN)
      else $error("first key did not advance");
   chk_second_key_arms: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_reg == PWL_KEY1_SEEN && key_wr && sfr_wdata == KEY_SECOND)
      |=> armed_reg && state_reg == PWL_ARMED)
      else $error("second key did not arm");
   chk_wrong_first_key: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_reg == PWL_LOCKED && sfr_access && !(key_wr && sfr_wdata == KEY_FIRST))
      |=> state_reg == PWL_LOCKED)
      else $error("progress without first key");
   chk_armed_needs_keys: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(armed_reg)
      |-> $past(state_reg == PWL_KEY1_SEEN) && $past(key_wr) && $past(sfr_wdata) == KEY_SECOND)
      else $error("armed without both keys");
   chk_armed_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (armed_reg && !sfr_access)
      |=> armed_reg)
      else $error("arming lost on idle cycle");
   chk_grant_oc_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (protect_en && state_reg == PWL_ARMED && prot_wr && sel_output_control)
      |=> oc_we_reg && wdata_reg == $past(sfr_wdata))
      else $error("unlocked output-control write lost");
   chk_grant_fc_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (protect_en && state_reg == PWL_ARMED && prot_wr && sel_fault_control)
      |=> fc_we_reg && wdata_reg == $past(sfr_wdata))
      else $error("unlocked fault-control write lost");
   chk_blocked_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
      blocked_reg |-> $past(prot_wr) && $past(protect_en)
      && $past(state_reg != PWL_ARMED))
      else $error("write refused without cause");
   chk_fc_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fc_we_reg |-> $past(prot_wr) && $past(sel_fault_control)
      && ($past(!protect_en) || $past(state_reg == PWL_ARMED)))
      else $error("fault-control enable without cause");
   chk_open_fc_passes: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!protect_en && prot_wr && sel_fault_control)
      |=> fc_we_reg && !blocked_reg)
      else $error("fault-control write lost with protection off");
   chk_wdata_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!oc_we_reg && !fc_we_reg && $past(rst_n))
      |-> $stable(wdata_reg))
      else $error("write data moved without a grant");
   chk_read_inert: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (sfr_access && !sfr_write)
      |=> !oc_we_reg && !fc_we_reg && !blocked_reg)
      else $error("read produced a write enable");
   chk_key_inert: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (key_wr && !sel_output_control && !sel_fault_control)
      |=> !oc_we_reg && !fc_we_reg && !blocked_reg)
      else $error("key write reached a protected register");

   cov_unlock_oc: cover property (@(posedge sys_clk) disable iff (!rst_n) oc_we_reg && protect_en);
   cov_unlock_fc: cover property (@(posedge sys_clk) disable iff (!rst_n) fc_we_reg && protect_en);
   cov_blocked:   cover property (@(posedge sys_clk) disable iff (!rst_n) blocked_reg);
   cov_open:      cover property (@(posedge sys_clk) disable iff (!rst_n) oc_we_reg && !protect_en);
   cov_idle_arm:  cover property (@(posedge sys_clk) disable iff (!rst_n) armed_reg && !sfr_access);
endmodule : pwl_write_lock
`default_nettype wire

// ---- verif/tb_pwm_register_write_lock.sv ----
// Purpose: self-checking bench for the pwm register write lock
// Assumes: inputs change 1 ns after the rising edge
// Notes:   outputs are judged one edge after the access that causes them
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_register_write_lock;
   import pwl_pkg::*;
   logic                   sys_clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic [OPT_W-1:0]       opt_word = OPT_WORD_ERASED;
   logic                   acc = 1'b0;
   logic                   wr = 1'b0;
   logic                   s_key = 1'b0;
   logic                   s_oc = 1'b0;
   logic                   s_fc = 1'b0;
   logic [DATA_W-1:0]      wdata = 16'h0000;
   wire logic              oc_we, fc_we, armed, blocked;
   wire logic [DATA_W-1:0] pwdata;
   int                     mismatches = 0;
   int                     checks = 0;
   always #50 sys_clk = ~sys_clk;
   pwl_write_lock uut (.sys_clk(sys_clk), .rst_n(rst_n), .device_options_config_word(opt_word),
      .sfr_access(acc), .sfr_write(wr), .sel_key(s_key), .sel_output_control(s_oc),
      .sel_fault_control(s_fc), .sfr_wdata(wdata), .pwm_output_control_we(oc_we),
      .pwm_fault_control_we(fc_we), .pwm_wdata(pwdata), .unlock_armed(armed), .write_blocked(blocked));
   task automatic chk(input bit ok, input string msg);
      checks++;
      if (!ok) begin
         mismatches++;
         $display("ERROR at %0t: %s", $time, msg);
      end
   endtask : chk
   // signals stay up after the edge so back-to-back calls never drive twice in one step
   task automatic access(input logic w, input logic k, input logic o, input logic f, input logic [15:0] d);
      acc = 1'b1;
      wr = w;
      s_key = k;
      s_oc = o;
      s_fc = f;
      wdata = d;
      @(posedge sys_clk);
      #1;
   endtask : access
   task automatic idle();
      acc = 1'b0;
      @(posedge sys_clk);
      #1;
   endtask : idle
   task automatic do_reset(input logic [15:0] word);
      acc = 1'b0;
      rst_n = 1'b0;
      opt_word = word;
      repeat (4) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
   endtask : do_reset
   task automatic unlock_write(input logic o, input logic [15:0] d);
      access(1'b1, 1'b1, 1'b0, 1'b0, KEY_FIRST);
      access(1'b1, 1'b1, 1'b0, 1'b0, KEY_SECOND);
      chk(armed === 1'b1, "not armed after keys");
      access(1'b1, 1'b0, o, !o, d);
      chk(oc_we === o && fc_we === !o && pwdata === d && blocked === 1'b0, "granted write missing");
      chk(armed === 1'b0, "still armed after write");
   endtask : unlock_write
   task automatic locked_default();
      chk(armed === 1'b0 && oc_we === 1'b0 && fc_we === 1'b0 && blocked === 1'b0 && pwdata === 16'h0000,
          "outputs not quiet after reset");
      access(1'b1, 1'b0, 1'b1, 1'b0, 16'h1111);
      chk(blocked === 1'b1 && oc_we === 1'b0, "write passed while locked");
      idle();
   endtask : locked_default
   task automatic one_per_unlock();
      unlock_write(1'b0, 16'h0a0a);
      access(1'b1, 1'b0, 1'b1, 1'b0, 16'hf000);
      chk(blocked === 1'b1 && oc_we === 1'b0 && pwdata === 16'h0a0a, "second write passed");
      idle();
      unlock_write(1'b1, 16'hf000);
      idle();
   endtask : one_per_unlock
   task automatic interrupted();
      access(1'b1, 1'b1, 1'b0, 1'b0, KEY_FIRST);
      access(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
      access(1'b1, 1'b1, 1'b0, 1'b0, KEY_SECOND);
      access(1'b1, 1'b0, 1'b0, 1'b1, 16'h2222);
      chk(blocked === 1'b1 && fc_we === 1'b0, "interrupted keys granted");
      access(1'b1, 1'b1, 1'b0, 1'b0, KEY_FIRST);
      access(1'b1, 1'b1, 1'b0, 1'b0, KEY_SECOND);
      access(1'b0, 1'b0, 1'b0, 1'b1, 16'h0000);
      access(1'b1, 1'b0, 1'b0, 1'b1, 16'h3333);
      chk(blocked === 1'b1 && fc_we === 1'b0, "write after other access granted");
      idle();
   endtask : interrupted
   task automatic wrong_key();
      access(1'b1, 1'b1, 1'b0, 1'b0, 16'habce);
      access(1'b1, 1'b1, 1'b0, 1'b0, KEY_SECOND);
      chk(armed === 1'b0, "armed by wrong key");
      access(1'b1, 1'b0, 1'b1, 1'b0, 16'h4444);
      chk(blocked === 1'b1 && oc_we === 1'b0, "wrong key granted");
      access(1'b1, 1'b1, 1'b0, 1'b0, KEY_FIRST);
      access(1'b1, 1'b1, 1'b0, 1'b0, KEY_SECOND);
      access(1'b1, 1'b1, 1'b0, 1'b0, KEY_FIRST);
      chk(armed === 1'b0, "key write while armed kept the gate open");
      access(1'b1, 1'b0, 1'b0, 1'b1, 16'h8888);
      chk(blocked === 1'b1 && fc_we === 1'b0, "write after spent unlock granted");
      idle();
   endtask : wrong_key
   task automatic gap_unlock();
      access(1'b1, 1'b1, 1'b0, 1'b0, KEY_FIRST);
      idle();
      access(1'b1, 1'b1, 1'b0, 1'b0, KEY_SECOND);
      idle();
      chk(armed === 1'b1, "idle cycle broke the unlock");
      access(1'b1, 1'b0, 1'b1, 1'b0, 16'h7777);
      chk(oc_we === 1'b1 && pwdata === 16'h7777 && blocked === 1'b0, "write after idle gap refused");
      idle();
   endtask : gap_unlock
   task automatic unprotected();
      do_reset(16'hfffe);
      chk(armed === 1'b0 && oc_we === 1'b0 && fc_we === 1'b0 && blocked === 1'b0 && pwdata === 16'h0000,
          "outputs not quiet after second reset");
      access(1'b1, 1'b0, 1'b1, 1'b0, 16'h5555);
      chk(oc_we === 1'b1 && blocked === 1'b0 && pwdata === 16'h5555, "free write refused");
      access(1'b1, 1'b0, 1'b0, 1'b1, 16'h6666);
      chk(fc_we === 1'b1 && pwdata === 16'h6666, "free write refused");
      idle();
   endtask : unprotected
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   // about 45 cycles of traffic; generous margin before calling it a hang
   initial begin
      #(100 * 500);
      mismatches++;
      report_and_stop();
   end
   initial begin
      do_reset(OPT_WORD_ERASED);
      locked_default();
      one_per_unlock();
      interrupted();
      wrong_key();
      gap_unlock();
      unprotected();
      report_and_stop();
   end
endmodule : tb_pwm_register_write_lock
`default_nettype wire
